// ===== design/dram_refresh_pkg.sv
// Constants and types for the DRAM refresh and synchronous DRAM signalling block.
//==============================================================================
package dram_refresh_pkg;

  localparam int unsigned CNT_W            = 8;
  localparam int unsigned PRESCALE_W       = 12;
  localparam logic [CNT_W-1:0] CNT_RESET   = 8'h00;
  localparam logic [2:0] LEN_RESET         = 3'h0;

  // Prescaler tap masks for clock select values 1 to 7; 0 stops the counter.
  localparam logic [PRESCALE_W-1:0] DIV4_MASK    = 12'h003;
  localparam logic [PRESCALE_W-1:0] DIV16_MASK   = 12'h00f;
  localparam logic [PRESCALE_W-1:0] DIV64_MASK   = 12'h03f;
  localparam logic [PRESCALE_W-1:0] DIV256_MASK  = 12'h0ff;
  localparam logic [PRESCALE_W-1:0] DIV1024_MASK = 12'h3ff;
  localparam logic [PRESCALE_W-1:0] DIV2048_MASK = 12'h7ff;
  localparam logic [PRESCALE_W-1:0] DIV4096_MASK = 12'hfff;

  localparam logic [2:0] MEMTYPE_SDRAM_A3   = 3'h2;
  localparam logic [2:0] MEMTYPE_SDRAM_A23  = 3'h3;
  localparam logic [1:0] BUS_SIZE_32        = 2'h3;
  localparam logic [3:0] BURST_LEN_4        = 4'h4;
  localparam logic [3:0] BURST_LEN_8        = 4'h8;
  localparam logic [5:0] SINGLE_BYTES_4     = 6'h10;
  localparam logic [5:0] SINGLE_BYTES_8     = 6'h20;
  localparam int unsigned ROW_SHIFT_BASE    = 8;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_REF, CMD_SELF, CMD_PALL, CMD_PRE, CMD_ACTV,
    CMD_READ, CMD_READA, CMD_WRIT, CMD_WRITA, CMD_MRS
  } sdram_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_CAS      = 3'b001,
    ST_RAS      = 3'b011,
    ST_PRE      = 3'b010,
    ST_SELF_CAS = 3'b110,
    ST_SELF     = 3'b111,
    ST_SELF_PRE = 3'b101
  } refresh_state_t;

endpackage : dram_refresh_pkg

// ===== design/dram_refresh_ctrl.sv
// Refresh timing, self-refresh and synchronous DRAM signalling for the memory bus.
`timescale 1ns/1ns
module dram_refresh_ctrl (
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Refresh timer configuration.
  input  wire logic [2:0]            i_refresh_clock_select,
  input  wire logic [7:0]            i_refresh_interval_constant,
  input  wire logic                  i_refresh_counter_load,
  input  wire logic [7:0]            i_refresh_counter_wdata,
  input  wire logic                  i_refresh_mode_select,
  input  wire logic                  i_refresh_enable_bit,
  // Memory control configuration.
  input  wire logic [2:0]            i_ras_active_length,
  input  wire logic [2:0]            i_ras_precharge_length,
  input  wire logic                  i_strobe_float_control,
  input  wire logic [2:0]            i_memory_type_select,
  input  wire logic [1:0]            i_bus_size_field,
  input  wire logic                  i_burst_enable_bit,
  input  wire logic                  i_burst_len8_enable,
  input  wire logic                  i_little_endian,
  input  wire logic [2:0]            i_address_mux_select,
  input  wire logic                  i_address_mux_extension,
  // Bus and power state.
  input  wire logic                  i_bus_cycle_busy,
  input  wire logic                  i_bus_released,
  input  wire logic                  i_standby,
  input  wire logic                  i_self_refresh_req,
  input  wire logic                  i_freq_change,
  input  wire logic                  i_clock_unstable,
  // Synchronous DRAM access request.
  input  wire logic [3:0]            i_sdram_cmd,
  input  wire logic                  i_access_area3,
  input  wire logic                  i_row_phase,
  input  wire logic [25:0]           i_access_addr,
  input  wire logic [1:0]            i_access_size,
  input  wire logic                  i_beat_needed,
  input  wire logic                  i_beat_write,
  // Refresh status.
  output logic                       o_back_n,
  output logic                       o_refresh_pending,
  output logic                       o_refresh_active,
  output logic                       o_self_refresh_active,
  output logic [7:0]                 o_refresh_counter,
  // Memory strobes with output enables.
  output logic                       o_ras_n,
  output logic                       o_ras_oe,
  output logic [3:0]                 o_cas_n,
  output logic                       o_cas_oe,
  output logic                       o_column_strobe_sdram_n,
  output logic                       o_rd_wr,
  output logic                       o_area2_select_n,
  output logic                       o_area3_select_n,
  output logic                       o_cke,
  output logic [3:0]                 o_byte_lane_mask,
  output logic [25:0]                o_addr,
  // Synchronous DRAM configuration status.
  output logic                       o_sdram_area2,
  output logic                       o_sdram_area3,
  output logic                       o_bus_size_ok,
  output logic [3:0]                 o_burst_length,
  output logic [5:0]                 o_single_transfer_bytes
);

  //============================================================================
  // Refresh timer.
  logic [11:0]                       prescale_ff;
  logic [11:0]                       nxt_prescale;
  logic [7:0]                        counter_ff;
  logic [7:0]                        nxt_counter;
  logic [11:0]                       tap_mask;
  logic                              tick;
  logic                              match;
  logic                              refresh_on;

  always_comb begin
    case (i_refresh_clock_select)
      3'h1:    tap_mask = dram_refresh_pkg::DIV4_MASK;
      3'h2:    tap_mask = dram_refresh_pkg::DIV16_MASK;
      3'h3:    tap_mask = dram_refresh_pkg::DIV64_MASK;
      3'h4:    tap_mask = dram_refresh_pkg::DIV256_MASK;
      3'h5:    tap_mask = dram_refresh_pkg::DIV1024_MASK;
      3'h6:    tap_mask = dram_refresh_pkg::DIV2048_MASK;
      default: tap_mask = dram_refresh_pkg::DIV4096_MASK;
    endcase
    // Distributed refresh only while enabled, and not in standby.
    refresh_on = !i_refresh_mode_select && i_refresh_enable_bit && !i_standby;
    tick  = (i_refresh_clock_select != 3'h0) && ((prescale_ff & tap_mask) == tap_mask);
    match = refresh_on && (i_refresh_clock_select != 3'h0)
            && (counter_ff == i_refresh_interval_constant);
    nxt_prescale = (i_refresh_clock_select == 3'h0) ? 12'h000 : prescale_ff + 12'h001;
    if (i_refresh_counter_load) begin
      nxt_counter = i_refresh_counter_wdata;
    end else if (match) begin
      nxt_counter = dram_refresh_pkg::CNT_RESET;
    end else if (tick) begin
      nxt_counter = counter_ff + 8'h01;
    end else begin
      nxt_counter = counter_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_ff <= 12'h000;
      counter_ff  <= dram_refresh_pkg::CNT_RESET;
    end else begin
      prescale_ff <= nxt_prescale;
      counter_ff  <= nxt_counter;
    end
  end

  //============================================================================
  // Refresh sequencer.
  dram_refresh_pkg::refresh_state_t state_ff;
  dram_refresh_pkg::refresh_state_t nxt_state;
  logic [2:0]                        len_ff;
  logic [2:0]                        nxt_len;
  logic                              pending_ff;
  logic                              nxt_pending;
  logic                              bus_free;
  logic                              start_refresh;
  logic                              self_exit_req;

  always_comb begin
    bus_free      = !i_bus_cycle_busy && !i_bus_released;
    start_refresh = (state_ff == dram_refresh_pkg::ST_IDLE) && pending_ff && bus_free
                    && !i_self_refresh_req;
    self_exit_req = 1'b0;
    nxt_state     = state_ff;
    nxt_len       = len_ff;
    case (state_ff)
      dram_refresh_pkg::ST_IDLE: begin
        if (start_refresh) begin
          nxt_state = dram_refresh_pkg::ST_CAS;
        end else if (i_self_refresh_req && bus_free) begin
          nxt_state = dram_refresh_pkg::ST_SELF_CAS;
        end
      end
      dram_refresh_pkg::ST_CAS: begin
        nxt_state = dram_refresh_pkg::ST_RAS;
        nxt_len   = i_ras_active_length;
      end
      dram_refresh_pkg::ST_RAS: begin
        if (len_ff == 3'h0) begin
          nxt_state = dram_refresh_pkg::ST_PRE;
          nxt_len   = i_ras_precharge_length;
        end else begin
          nxt_len = len_ff - 3'h1;
        end
      end
      dram_refresh_pkg::ST_PRE: begin
        if (len_ff == 3'h0) begin
          nxt_state = dram_refresh_pkg::ST_IDLE;
        end else begin
          nxt_len = len_ff - 3'h1;
        end
      end
      dram_refresh_pkg::ST_SELF_CAS: begin
        nxt_state = dram_refresh_pkg::ST_SELF;
      end
      dram_refresh_pkg::ST_SELF: begin
        // Self-refresh holds through standby until the request drops; reset returns it to idle.
        if (!i_self_refresh_req) begin
          nxt_state = dram_refresh_pkg::ST_SELF_PRE;
          nxt_len   = i_ras_precharge_length;
        end
      end
      dram_refresh_pkg::ST_SELF_PRE: begin
        if (len_ff == 3'h0) begin
          nxt_state     = dram_refresh_pkg::ST_IDLE;
          self_exit_req = 1'b1;
        end else begin
          nxt_len = len_ff - 3'h1;
        end
      end
      default: begin
        nxt_state = dram_refresh_pkg::ST_IDLE;
      end
    endcase
    // A fresh request wins over the clear and replaces any waiting one.
    if (match || self_exit_req) begin
      nxt_pending = 1'b1;
    end else if (start_refresh) begin
      nxt_pending = 1'b0;
    end else begin
      nxt_pending = pending_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff   <= dram_refresh_pkg::ST_IDLE;
      len_ff     <= dram_refresh_pkg::LEN_RESET;
      pending_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      len_ff     <= nxt_len;
      pending_ff <= nxt_pending;
    end
  end

  //============================================================================
  // Configuration decode.
  logic                              sdram_a2;
  logic                              sdram_a3;
  logic                              in_self;

  always_comb begin
    sdram_a3 = (i_memory_type_select == dram_refresh_pkg::MEMTYPE_SDRAM_A3)
               || (i_memory_type_select == dram_refresh_pkg::MEMTYPE_SDRAM_A23);
    sdram_a2 = (i_memory_type_select == dram_refresh_pkg::MEMTYPE_SDRAM_A23);
    in_self  = (state_ff == dram_refresh_pkg::ST_SELF_CAS)
               || (state_ff == dram_refresh_pkg::ST_SELF);
  end

  //============================================================================
  // Command and strobe encoding.
  logic                              nxt_ras_n;
  logic                              nxt_cas_n;
  logic                              nxt_we;
  logic                              nxt_a10;
  logic                              nxt_cs_active;
  logic                              nxt_cke;
  logic                              nxt_back_n;
  logic                              nxt_strobe_oe;
  logic                              ras_n_ff;
  logic                              cas_n_ff;
  logic                              we_ff;
  logic                              cs2_n_ff;
  logic                              cs3_n_ff;
  logic                              cke_ff;
  logic                              back_n_ff;
  logic                              strobe_oe_ff;
  logic                              nxt_cs2_n;
  logic                              nxt_cs3_n;
  logic [25:0]                       addr_ff;
  logic [25:0]                       nxt_addr;
  logic [4:0]                        row_shift;
  logic                              refreshing;

  always_comb begin
    refreshing    = (state_ff != dram_refresh_pkg::ST_IDLE);
    nxt_ras_n     = 1'b1;
    nxt_cas_n     = 1'b1;
    nxt_we        = 1'b1;
    nxt_a10       = 1'b0;
    nxt_cs_active = 1'b0;
    case (state_ff)
      // Column strobes lead, then RAS joins them; in SDRAM this is REF or SELF.
      dram_refresh_pkg::ST_CAS, dram_refresh_pkg::ST_SELF_CAS: begin
        nxt_cas_n = 1'b0;
      end
      dram_refresh_pkg::ST_RAS, dram_refresh_pkg::ST_SELF: begin
        nxt_cas_n     = 1'b0;
        nxt_ras_n     = 1'b0;
        nxt_cs_active = 1'b1;
      end
      default: begin
        if (!refreshing && !i_bus_released) begin
          nxt_cs_active = (i_sdram_cmd != dram_refresh_pkg::CMD_NOP);
          case (i_sdram_cmd)
            dram_refresh_pkg::CMD_REF, dram_refresh_pkg::CMD_SELF: begin
              nxt_ras_n = 1'b0;
              nxt_cas_n = 1'b0;
            end
            dram_refresh_pkg::CMD_PALL, dram_refresh_pkg::CMD_PRE: begin
              nxt_ras_n = 1'b0;
              nxt_we    = 1'b0;
              nxt_a10   = (i_sdram_cmd == dram_refresh_pkg::CMD_PALL);
            end
            dram_refresh_pkg::CMD_ACTV: begin
              nxt_ras_n = 1'b0;
            end
            dram_refresh_pkg::CMD_READ, dram_refresh_pkg::CMD_READA: begin
              nxt_cas_n = 1'b0;
              nxt_a10   = (i_sdram_cmd == dram_refresh_pkg::CMD_READA);
            end
            dram_refresh_pkg::CMD_WRIT, dram_refresh_pkg::CMD_WRITA: begin
              nxt_cas_n = 1'b0;
              nxt_we    = 1'b0;
              nxt_a10   = (i_sdram_cmd == dram_refresh_pkg::CMD_WRITA);
            end
            dram_refresh_pkg::CMD_MRS: begin
              nxt_ras_n = 1'b0;
              nxt_cas_n = 1'b0;
              nxt_we    = 1'b0;
            end
            default: begin
              nxt_cs_active = 1'b0;
            end
          endcase
        end
      end
    endcase
    // Only the area selects are per area; refresh selects every SDRAM area.
    nxt_cs3_n = !(nxt_cs_active && sdram_a3 && (refreshing || i_access_area3));
    nxt_cs2_n = !(nxt_cs_active && sdram_a2 && (refreshing || !i_access_area3));
    nxt_cke   = !(i_freq_change || i_clock_unstable || in_self);
    // Acknowledge goes high while a refresh waits; otherwise it tracks the release.
    nxt_back_n    = nxt_pending ? 1'b1 : !i_bus_released;
    nxt_strobe_oe = !((i_bus_released || i_standby) && !i_strobe_float_control);
    // Row phase shifts by the multiplex setting; unguaranteed pins are driven low.
    row_shift = 5'(dram_refresh_pkg::ROW_SHIFT_BASE) + {2'h0, i_address_mux_select}
                + {4'h0, i_address_mux_extension};
    if (refreshing) begin
      nxt_addr = 26'h0000000;
    end else if (i_row_phase) begin
      nxt_addr = (i_access_addr >> row_shift) & 26'h003fffc;
    end else begin
      nxt_addr = i_access_addr & 26'h003fffc;
    end
    nxt_addr[12] = nxt_addr[12] | nxt_a10;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ras_n_ff     <= 1'b1;
      cas_n_ff     <= 1'b1;
      we_ff        <= 1'b1;
      cs2_n_ff     <= 1'b1;
      cs3_n_ff     <= 1'b1;
      cke_ff       <= 1'b1;
      back_n_ff    <= 1'b1;
      strobe_oe_ff <= 1'b1;
      addr_ff      <= 26'h0000000;
    end else begin
      ras_n_ff     <= nxt_ras_n;
      cas_n_ff     <= nxt_cas_n;
      we_ff        <= nxt_we;
      cs2_n_ff     <= nxt_cs2_n;
      cs3_n_ff     <= nxt_cs3_n;
      cke_ff       <= nxt_cke;
      back_n_ff    <= nxt_back_n;
      strobe_oe_ff <= nxt_strobe_oe;
      addr_ff      <= nxt_addr;
    end
  end

  //============================================================================
  // Byte lane masks.
  logic [3:0]                        lane_need;
  logic [3:0]                        mask_ff;
  logic [3:0]                        nxt_mask;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      always_comb begin
        case (i_access_size)
          2'h0:    lane_need[lane] = (i_access_addr[1:0] == 2'(lane));
          2'h1:    lane_need[lane] = (i_access_addr[1] == (lane >= 2));
          default: lane_need[lane] = 1'b1;
        endcase
        // Low enables a lane; unneeded write beats keep every lane masked.
        if (!i_beat_needed && i_beat_write) begin
          nxt_mask[lane] = 1'b1;
        end else if (i_little_endian) begin
          nxt_mask[lane] = !lane_need[lane];
        end else begin
          nxt_mask[lane] = !lane_need[3 - lane];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_ff <= 4'hf;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  //============================================================================
  // Outputs.
  assign o_back_n                = back_n_ff;
  assign o_refresh_pending       = pending_ff;
  assign o_refresh_active        = refreshing;
  assign o_self_refresh_active   = in_self;
  assign o_refresh_counter       = counter_ff;
  assign o_ras_n                 = ras_n_ff;
  assign o_ras_oe                = strobe_oe_ff;
  assign o_cas_n                 = {4{cas_n_ff}};
  assign o_cas_oe                = strobe_oe_ff;
  assign o_column_strobe_sdram_n = cas_n_ff;
  assign o_rd_wr                 = we_ff;
  assign o_area2_select_n        = cs2_n_ff;
  assign o_area3_select_n        = cs3_n_ff;
  assign o_cke                   = cke_ff;
  assign o_byte_lane_mask        = mask_ff;
  assign o_addr                  = addr_ff;
  assign o_sdram_area2           = sdram_a2;
  assign o_sdram_area3           = sdram_a3;
  // Burst enable has no effect on synchronous DRAM bursts.
  assign o_bus_size_ok  = (i_bus_size_field == dram_refresh_pkg::BUS_SIZE_32)
                          || (!sdram_a3 && !i_burst_enable_bit && i_burst_enable_bit);
  assign o_burst_length = i_burst_len8_enable ? dram_refresh_pkg::BURST_LEN_8
                                              : dram_refresh_pkg::BURST_LEN_4;
  assign o_single_transfer_bytes = i_burst_len8_enable ? dram_refresh_pkg::SINGLE_BYTES_8
                                                       : dram_refresh_pkg::SINGLE_BYTES_4;

endmodule : dram_refresh_ctrl

// ===== tb/dram_refresh_ctrl_properties.sv
// Port-level property checker for the refresh and signalling block.
`timescale 1ns/1ns
module dram_refresh_ctrl_properties (
  // Clock, reset, controls and the refresh counter output.
  input wire logic       i_clk, i_rst_n, i_refresh_enable_bit, i_refresh_mode_select,
  input wire logic       i_refresh_counter_load, i_standby, i_bus_cycle_busy, i_bus_released,
  input wire logic       i_strobe_float_control, i_freq_change, i_clock_unstable,
  input wire logic       i_burst_len8_enable,
  input wire logic [1:0] i_bus_size_field,
  input wire logic [2:0] i_refresh_clock_select, i_memory_type_select, i_ras_active_length,
  input wire logic [7:0] i_refresh_interval_constant, o_refresh_counter,
  // Observed outputs.
  input wire logic       o_back_n, o_refresh_pending, o_refresh_active, o_self_refresh_active,
  input wire logic       o_ras_n, o_ras_oe, o_cas_oe, o_cke, o_sdram_area2, o_sdram_area3,
  input wire logic       o_bus_size_ok,
  input wire logic [3:0] o_cas_n, o_burst_length,
  input wire logic [5:0] o_single_transfer_bytes
);
  // ========
  // Row strobe low-time counter and the timer match condition.
  logic [3:0] ras_low_ff;
  logic [3:0] nxt_ras_low;
  always_comb nxt_ras_low = o_ras_n ? 4'h0 : ras_low_ff + 4'h1;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ras_low_ff <= 4'h0;
    else ras_low_ff <= nxt_ras_low;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence match_s;
    i_refresh_enable_bit && !i_refresh_mode_select && !i_standby && !i_refresh_counter_load
      && i_refresh_clock_select != 3'h0 && o_refresh_counter == i_refresh_interval_constant;
  endsequence
  sequence strobe_in_s;
    $fell(o_ras_n) && (o_refresh_active || o_self_refresh_active);
  endsequence
  timer_match_a: assert property (
    match_s |=> o_refresh_pending && o_back_n && o_refresh_counter == 8'h00)
    else $error("match not served");
  mode_off_a: assert property (
    (!i_refresh_enable_bit || i_refresh_mode_select) && !o_refresh_pending
      && !o_self_refresh_active |=> !o_refresh_pending) else $error("refresh while off");
  start_free_a: assert property (
    $rose(o_refresh_active) |-> !$past(i_bus_cycle_busy) && !$past(i_bus_released))
    else $error("refresh on busy bus");
  cas_first_a: assert property (
    strobe_in_s |-> o_cas_n == 4'h0 && $past(o_cas_n) == 4'h0) else $error("ras before cas");
  ras_len_a: assert property (
    $rose(o_ras_n) && $past(o_refresh_active) && !$past(o_self_refresh_active, 2)
      |-> ras_low_ff == {1'h0, i_ras_active_length} + 4'h1) else $error("ras length");
  exit_req_a: assert property (
    $fell(o_self_refresh_active) |-> ##[0:10] o_refresh_pending) else $error("no exit request");
  cke_low_a: assert property (
    i_freq_change || i_clock_unstable |=> !o_cke) else $error("cke not low");
  strobe_float_a: assert property (
    i_bus_released || i_standby |=> o_ras_oe == $past(i_strobe_float_control)
      && o_cas_oe == $past(i_strobe_float_control)) else $error("strobe enable");
  area_map_a: assert property (
    o_sdram_area3 == (i_memory_type_select inside {3'h2, 3'h3})
      && o_sdram_area2 == (i_memory_type_select == 3'h3)) else $error("area map");
  burst_cfg_a: assert property (
    o_burst_length == (i_burst_len8_enable ? 4'h8 : 4'h4) && o_bus_size_ok == (i_bus_size_field
      == 2'h3) && o_single_transfer_bytes == (i_burst_len8_enable ? 6'h20 : 6'h10))
    else $error("burst setup");
endmodule : dram_refresh_ctrl_properties

bind dram_refresh_ctrl dram_refresh_ctrl_properties u_props (.*);

// ===== tb/bus_master_model.sv
// Outside bus master that borrows the bus and returns it on the acknowledge.
`timescale 1ns/1ns
module bus_master_model (
  // Clock, reset and arbitration.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_want_bus,
  input  wire logic i_back_n,
  output logic      o_bus_released
);
  logic return_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_bus_released, return_ff} <= 2'h0;
    end else begin
      return_ff      <= i_want_bus && (return_ff || (o_bus_released && i_back_n));
      o_bus_released <= i_want_bus && !return_ff;
    end
  end
endmodule : bus_master_model

// ===== tb/tb_dram_refresh_ctrl.sv
// Self-checking bench for the refresh and signalling block.
`timescale 1ns/1ns
module tb_dram_refresh_ctrl;
  // ========
  // Design signals and counters.
  logic i_clk, i_rst_n, i_refresh_counter_load, i_refresh_mode_select, i_refresh_enable_bit;
  logic i_strobe_float_control, i_burst_enable_bit, i_burst_len8_enable, i_little_endian;
  logic i_address_mux_extension, i_bus_cycle_busy, i_bus_released, i_standby, want_bus;
  logic i_self_refresh_req, i_freq_change, i_clock_unstable, i_access_area3, i_row_phase;
  logic i_beat_needed, i_beat_write, o_back_n, o_refresh_pending, o_refresh_active, o_rd_wr;
  logic o_self_refresh_active, o_ras_n, o_ras_oe, o_cas_oe, o_column_strobe_sdram_n, o_cke;
  logic o_area2_select_n, o_area3_select_n, o_sdram_area2, o_sdram_area3, o_bus_size_ok;
  logic [2:0] i_refresh_clock_select, i_ras_active_length, i_ras_precharge_length;
  logic [2:0] i_memory_type_select, i_address_mux_select;
  logic [1:0] i_bus_size_field, i_access_size;
  logic [3:0] i_sdram_cmd, o_cas_n, o_byte_lane_mask, o_burst_length;
  logic [5:0] o_single_transfer_bytes;
  logic [7:0] i_refresh_interval_constant, i_refresh_counter_wdata, o_refresh_counter;
  logic [25:0] i_access_addr, o_addr;
  int fail_count, compares, n, m;

  dram_refresh_ctrl dut (.*);
  bus_master_model u_master (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_want_bus(want_bus),
                             .i_back_n(o_back_n), .o_bus_released(i_bus_released));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  function automatic logic pick(input int k);
    case (k)
      0: return o_refresh_pending;
      1: return o_refresh_active;
      2: return o_self_refresh_active;
      default: return i_bus_released;
    endcase
  endfunction : pick

  task automatic wait_on(input int k, input logic v);
    int t;
    for (t = 0; t < 400 && pick(k) !== v; t++) @(negedge i_clk);
    if (t == 400) begin
      chk("wait bound", 8'h01, 8'h00);
      test_done();
    end
  endtask : wait_on

  task automatic count(input int k, input int c);
    m = 0;
    repeat (c) begin
      @(negedge i_clk);
      m += int'(pick(k) === 1'h1);
    end
  endtask : count

  task automatic arm(input logic [2:0] sel);
    @(posedge i_clk);
    {i_refresh_counter_load, i_refresh_clock_select} <= {1'h1, sel};
    @(posedge i_clk);
    i_refresh_counter_load <= 1'h0;
  endtask : arm

  task automatic t_timer();
    @(posedge i_clk);
    {i_ras_active_length, i_ras_precharge_length, i_refresh_enable_bit} <= {3'h2, 3'h1, 1'h1};
    arm(3'h0);
    repeat (6) @(negedge i_clk);
    chk("held count", 8'h02, o_refresh_counter);
    @(posedge i_clk);
    i_refresh_clock_select <= 3'h1;
    wait_on(0, 1'h1);
    chk("cleared count", 8'h00, o_refresh_counter);
    chk("ack", 8'h01, {7'h0, o_back_n});
    wait_on(1, 1'h1);
    for (m = 0; o_refresh_active === 1'h1 && m < 40; m++) begin
      n += int'(o_ras_n === 1'h0);
      @(negedge i_clk);
    end
    chk("ras cycles", 8'(n), 8'h03);
    chk("refresh cycles", 8'(m), 8'h06);
    @(posedge i_clk);
    i_refresh_mode_select <= 1'h1;
    count(0, 40);
    chk("mode off", 8'(m), 8'h00);
    @(posedge i_clk);
    i_refresh_mode_select <= 1'h0;
  endtask : t_timer

  task automatic t_defer();
    @(posedge i_clk);
    i_bus_cycle_busy <= 1'h1;
    arm(3'h1);
    wait_on(0, 1'h1);
    count(1, 40);
    chk("deferred", 8'(m), 8'h00);
    @(posedge i_clk);
    {i_bus_cycle_busy, i_refresh_clock_select} <= 4'h0;
    wait_on(1, 1'h1);
    wait_on(1, 1'h0);
    count(1, 30);
    chk("one refresh", 8'(m), 8'h00);
  endtask : t_defer

  task automatic t_release();
    @(posedge i_clk);
    want_bus <= 1'h1;
    wait_on(3, 1'h1);
    arm(3'h1);
    wait_on(0, 1'h1);
    @(posedge i_clk);
    i_refresh_clock_select <= 3'h0;
    wait_on(1, 1'h1);
    chk("bus regained", {7'h0, i_bus_released}, 8'h00);
    wait_on(1, 1'h0);
  endtask : t_release

  task automatic t_self();
    @(posedge i_clk);
    {want_bus, i_refresh_clock_select, i_self_refresh_req, i_standby,
     i_strobe_float_control} <= 7'h07;
    wait_on(2, 1'h1);
    repeat (3) @(negedge i_clk);
    chk("self cke", {7'h0, o_cke}, 8'h00);
    chk("strobes kept", {7'h0, o_ras_oe}, 8'h01);
    @(posedge i_clk);
    i_strobe_float_control <= 1'h0;
    repeat (2) @(negedge i_clk);
    chk("strobes float", {7'h0, o_ras_oe}, 8'h00);
    chk("still self", {7'h0, o_self_refresh_active}, 8'h01);
    @(posedge i_clk);
    {i_self_refresh_req, i_standby, i_strobe_float_control} <= 3'h1;
    wait_on(0, 1'h1);
    wait_on(1, 1'h1);
    wait_on(1, 1'h0);
  endtask : t_self

  task automatic t_signals();
    for (int k = 2; k >= 0; k--) begin
      @(posedge i_clk);
      {i_freq_change, i_clock_unstable} <= 2'(k);
      repeat (2) @(negedge i_clk);
      chk("cke", {7'h0, o_cke}, {7'h0, k == 0});
    end
    for (int k = 0; k < 11; k++) begin
      @(posedge i_clk);
      {i_memory_type_select, i_sdram_cmd, i_burst_len8_enable, i_little_endian} <= 9'(k * 37);
      {i_access_area3, i_access_addr, i_beat_needed, i_beat_write} <= {1'h1, 26'(k * 4), 2'(k)};
      {i_row_phase, i_access_size, i_address_mux_select, i_bus_size_field} <= 8'(k * 13);
      repeat (2) @(negedge i_clk);
      chk("area2 idle", {7'h0, o_area2_select_n}, 8'h01);
    end
  endtask : t_signals

  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    {i_rst_n, i_refresh_counter_load, i_refresh_mode_select, i_refresh_enable_bit,
     i_strobe_float_control, i_burst_enable_bit, i_burst_len8_enable, i_little_endian,
     i_address_mux_extension, i_bus_cycle_busy, i_standby, i_self_refresh_req, i_freq_change,
     i_clock_unstable, i_access_area3, i_row_phase, i_beat_needed, i_beat_write, want_bus} = '0;
    {i_refresh_clock_select, i_ras_active_length, i_ras_precharge_length, i_memory_type_select,
     i_address_mux_select, i_bus_size_field, i_access_size, i_sdram_cmd, i_access_addr} = '0;
    {i_refresh_interval_constant, i_refresh_counter_wdata} = {8'h03, 8'h02};
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(negedge i_clk);
    chk("idle cke", {7'h0, o_cke}, 8'h01);
    t_timer();
    t_defer();
    t_release();
    t_self();
    t_signals();
    test_done();
  end
endmodule : tb_dram_refresh_ctrl
